// >>> rrs_axil.sv
// Purpose: AXI4-Lite slave front end for the reset cause registers
// Assumes: one write and one read outstanding at most
// Notes: address and data taken in either order; answer one cycle after both
`timescale 1ns/10ps
`include "rrs_consts.svh"
module rrs_axil (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic [`RRS_ADDR_W-1:0]   awaddr,
    input  wire logic                     awvalid,
    output wire logic                     awready,
    input  wire logic [`RRS_DATA_W-1:0]   wdata,
    input  wire logic [`RRS_DATA_W/8-1:0] wstrb,
    input  wire logic                     wvalid,
    output wire logic                     wready,
    output logic      [1:0]               bresp,
    output wire logic                     bvalid,
    input  wire logic                     bready,
    input  wire logic [`RRS_ADDR_W-1:0]   araddr,
    input  wire logic                     arvalid,
    output wire logic                     arready,
    output logic      [`RRS_DATA_W-1:0]   rdata,
    output logic      [1:0]               rresp,
    output wire logic                     rvalid,
    input  wire logic                     rready,
    output wire logic                     wr_en,
    output rrs_pkg::rrs_wreq_t            wr_req,
    input  wire logic                     wr_err,
    output wire logic                     rd_en,
    output wire logic [`RRS_ADDR_W-1:0]   rd_addr,
    input  rrs_pkg::rrs_rans_t            rd_ans
);
    rrs_pkg::rrs_wr_st_t        wr_st_q;
    rrs_pkg::rrs_rd_st_t        rd_st_q;
    logic                       aw_hold_q;
    logic                       w_hold_q;
    logic [`RRS_ADDR_W-1:0]     aw_addr_q;
    logic [`RRS_DATA_W-1:0]     w_data_q;
    logic [`RRS_DATA_W/8-1:0]   w_strb_q;
    wire                        aw_take;
    wire                        w_take;

    assign awready       = ~aw_hold_q & (wr_st_q == rrs_pkg::RRS_WR_IDLE);
    assign wready        = ~w_hold_q & (wr_st_q == rrs_pkg::RRS_WR_IDLE);
    assign aw_take       = awvalid & awready;
    assign w_take        = wvalid & wready;
    assign wr_en         = (aw_hold_q | aw_take) & (w_hold_q | w_take);
    assign wr_req.addr   = aw_hold_q ? aw_addr_q : awaddr;
    assign wr_req.data   = w_hold_q ? w_data_q : wdata;
    assign wr_req.strb   = w_hold_q ? w_strb_q : wstrb;
    assign bvalid        = (wr_st_q == rrs_pkg::RRS_WR_RESP);
    assign arready       = (rd_st_q == rrs_pkg::RRS_RD_IDLE);
    assign rd_en         = arvalid & arready;
    assign rd_addr       = araddr;
    assign rvalid        = (rd_st_q == rrs_pkg::RRS_RD_RESP);

    // half-taken writes wait here so the master may offer either channel first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
        end else begin
            aw_hold_q <= ~wr_en & (aw_hold_q | aw_take);
            w_hold_q  <= ~wr_en & (w_hold_q | w_take);
            if (aw_take) aw_addr_q <= awaddr;
            if (w_take) w_data_q <= wdata;
            if (w_take) w_strb_q <= wstrb;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_st_q <= rrs_pkg::RRS_WR_IDLE;
            bresp   <= `RRS_RESP_OKAY;
        end else begin
            unique case (wr_st_q)
                rrs_pkg::RRS_WR_IDLE: begin
                    if (wr_en) begin
                        wr_st_q <= rrs_pkg::RRS_WR_RESP;
                        bresp   <= wr_err ? `RRS_RESP_DECERR : `RRS_RESP_OKAY;
                    end
                end
                rrs_pkg::RRS_WR_RESP: begin
                    if (bready) wr_st_q <= rrs_pkg::RRS_WR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_st_q <= rrs_pkg::RRS_RD_IDLE;
            rdata   <= '0;
            rresp   <= `RRS_RESP_OKAY;
        end else begin
            unique case (rd_st_q)
                rrs_pkg::RRS_RD_IDLE: begin
                    if (rd_en) begin
                        rd_st_q <= rrs_pkg::RRS_RD_RESP;
                        rdata   <= rd_ans.data;
                        rresp   <= rd_ans.resp;
                    end
                end
                rrs_pkg::RRS_RD_RESP: begin
                    if (rready) rd_st_q <= rrs_pkg::RRS_RD_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> rrs_consts.svh
// Purpose: constants of the reset source combiner and cause recorder
// Assumes: 32-bit AXI4-Lite register bus, 8-bit byte address decode
// Notes: all offsets, field positions, reset values and responses live here
// Summary of operation
// - any active reset source drives the master reset active, whichever source it is.
// - master reset forces a chosen register to a known value; others keep contents.
// - each kind of reset sets its own cause flag in the cause status register.
// - power-on reset clears every cause flag except power-on at bit 0, which is set.
// - software may write any cause flag to one, or to zero while its source is inactive.
// - writing a cause flag only changes stored status, never starts a reset.
// - one combiner merges all sources into one master reset and alone drives it.
// - sources are power-on, brown-out, pin, software, watchdog, mismatch, trap, illegal.
`ifndef RRS_CONSTS_SVH
`define RRS_CONSTS_SVH

`define RRS_ADDR_W          8
`define RRS_DATA_W          32
`define RRS_CAUSE_W         8

`define RRS_OFF_CAUSE       8'h00
`define RRS_OFF_IRQ_STAT    8'h04
`define RRS_OFF_IRQ_MASK    8'h08
`define RRS_OFF_KEEP        8'h0c
`define RRS_OFF_VOLATILE    8'h10
`define RRS_OFF_SRC_LIVE    8'h14

`define RRS_BIT_POR         0
`define RRS_BIT_BROWN       1
`define RRS_BIT_PIN         2
`define RRS_BIT_SOFT        3
`define RRS_BIT_WDOG        4
`define RRS_BIT_CFG         5
`define RRS_BIT_TRAP        6
`define RRS_BIT_ILLEG       7

`define RRS_CAUSE_POR_VAL   8'h01
`define RRS_IRQ_STAT_RST    8'h00
`define RRS_IRQ_MASK_RST    8'h00
`define RRS_KEEP_RST        32'h0000_0000
`define RRS_VOLATILE_RST    32'h0000_0000

`define RRS_RESP_OKAY       2'h0
`define RRS_RESP_DECERR     2'h3

`endif

// >>> rrs_pkg.sv
// Purpose: types of the reset source combiner
// Assumes: constants come from rrs_consts.svh
// Notes: nothing here is imported; users write rrs_pkg::name
`include "rrs_consts.svh"
package rrs_pkg;

    typedef struct packed {
        logic brown_out_reset;
        logic master_clear_pin_reset;
        logic software_reset_instruction;
        logic watchdog_timeout_reset;
        logic configuration_mismatch_reset;
        logic trap_conflict_reset;
        logic illegal_opcode;
        logic uninit_wreg;
        logic security;
    } rrs_src_t;

    typedef struct packed {
        logic [`RRS_ADDR_W-1:0]   addr;
        logic [`RRS_DATA_W-1:0]   data;
        logic [`RRS_DATA_W/8-1:0] strb;
    } rrs_wreq_t;

    typedef struct packed {
        logic [`RRS_DATA_W-1:0] data;
        logic [1:0]             resp;
    } rrs_rans_t;

    typedef enum logic [0:0] {
        RRS_WR_IDLE,
        RRS_WR_RESP
    } rrs_wr_st_t;

    typedef enum logic [0:0] {
        RRS_RD_IDLE,
        RRS_RD_RESP
    } rrs_rd_st_t;

endpackage

// >>> rrs_top.sv
// Purpose: combines reset sources into the master reset and records the cause
// Assumes: aresetn low is the power-on reset of this block and its bus
// Notes: cause, interrupt and keep registers survive the master reset
`timescale 1ns/10ps
`include "rrs_consts.svh"
module rrs_top (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  rrs_pkg::rrs_src_t             src,
    output logic                          master_reset_signal,
    output wire logic                     irq,
    input  wire logic [`RRS_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output wire logic                     s_axi_awready,
    input  wire logic [`RRS_DATA_W-1:0]   s_axi_wdata,
    input  wire logic [`RRS_DATA_W/8-1:0] s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output wire logic                     s_axi_wready,
    output wire logic [1:0]               s_axi_bresp,
    output wire logic                     s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [`RRS_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output wire logic                     s_axi_arready,
    output wire logic [`RRS_DATA_W-1:0]   s_axi_rdata,
    output wire logic [1:0]               s_axi_rresp,
    output wire logic                     s_axi_rvalid,
    input  wire logic                     s_axi_rready
);
    logic [`RRS_CAUSE_W-1:0]    cause_q;
    logic [`RRS_CAUSE_W-1:0]    cause_d;
    logic [`RRS_CAUSE_W-1:0]    cause_set_prev_q;
    logic [`RRS_CAUSE_W-1:0]    irq_stat_q;
    logic [`RRS_CAUSE_W-1:0]    irq_stat_d;
    logic [`RRS_CAUSE_W-1:0]    irq_mask_q;
    logic [`RRS_DATA_W-1:0]     keep_q;
    logic [`RRS_DATA_W-1:0]     volatile_q;
    logic [`RRS_DATA_W-1:0]     rd_mux;
    rrs_pkg::rrs_wreq_t         wr_req;
    rrs_pkg::rrs_rans_t         rd_ans;
    wire                        wr_en;
    wire                        rd_en;
    wire [`RRS_ADDR_W-1:0]      rd_addr;
    wire                        illegal_any;
    wire                        src_any;
    wire                        any_rst_w;
    wire [`RRS_CAUSE_W-1:0]     cause_set_w;
    wire [`RRS_CAUSE_W-1:0]     cause_evt_w;
    wire                        cause_wr_w;
    wire                        irq_stat_wr_w;
    wire                        irq_mask_wr_w;
    wire                        keep_wr_w;
    wire                        volatile_wr_w;
    wire                        wr_err;
    wire                        rd_err;

    function automatic logic reg_hit(input logic [`RRS_ADDR_W-1:0] a,
                                     input logic [`RRS_ADDR_W-1:0] off);
        reg_hit = (a[`RRS_ADDR_W-1:2] == off[`RRS_ADDR_W-1:2]);
    endfunction

    function automatic logic reg_mapped(input logic [`RRS_ADDR_W-1:0] a);
        reg_mapped = reg_hit(a, `RRS_OFF_CAUSE) | reg_hit(a, `RRS_OFF_IRQ_STAT)
                   | reg_hit(a, `RRS_OFF_IRQ_MASK) | reg_hit(a, `RRS_OFF_KEEP)
                   | reg_hit(a, `RRS_OFF_VOLATILE) | reg_hit(a, `RRS_OFF_SRC_LIVE);
    endfunction

    rrs_axil u_axil (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .wr_en   (wr_en),
        .wr_req  (wr_req),
        .wr_err  (wr_err),
        .rd_en   (rd_en),
        .rd_addr (rd_addr),
        .rd_ans  (rd_ans)
    );

    // three illegal conditions share one cause flag
    assign illegal_any = src.illegal_opcode | src.uninit_wreg | src.security;
    assign src_any     = |src;
    assign any_rst_w   = ~aresetn | src_any;

    assign cause_set_w[`RRS_BIT_POR]   = 1'b0;
    assign cause_set_w[`RRS_BIT_BROWN] = src.brown_out_reset;
    assign cause_set_w[`RRS_BIT_PIN]   = src.master_clear_pin_reset;
    assign cause_set_w[`RRS_BIT_SOFT]  = src.software_reset_instruction;
    assign cause_set_w[`RRS_BIT_WDOG]  = src.watchdog_timeout_reset;
    assign cause_set_w[`RRS_BIT_CFG]   = src.configuration_mismatch_reset;
    assign cause_set_w[`RRS_BIT_TRAP]  = src.trap_conflict_reset;
    assign cause_set_w[`RRS_BIT_ILLEG] = illegal_any;
    assign cause_evt_w = cause_set_w & ~cause_set_prev_q;

    assign cause_wr_w    = wr_en & reg_hit(wr_req.addr, `RRS_OFF_CAUSE) & wr_req.strb[0];
    assign irq_stat_wr_w = wr_en & reg_hit(wr_req.addr, `RRS_OFF_IRQ_STAT) & wr_req.strb[0];
    assign irq_mask_wr_w = wr_en & reg_hit(wr_req.addr, `RRS_OFF_IRQ_MASK) & wr_req.strb[0];
    assign keep_wr_w     = wr_en & reg_hit(wr_req.addr, `RRS_OFF_KEEP);
    assign volatile_wr_w = wr_en & reg_hit(wr_req.addr, `RRS_OFF_VOLATILE);
    assign wr_err        = ~reg_mapped(wr_req.addr);
    assign rd_err        = ~reg_mapped(rd_addr);

    // software value first, then live sources on top: an active source wins
    assign cause_d = (cause_wr_w ? wr_req.data[`RRS_CAUSE_W-1:0] : cause_q)
                   | cause_set_w;
    assign irq_stat_d = (irq_stat_q
                      & ~({`RRS_CAUSE_W{irq_stat_wr_w}} & wr_req.data[`RRS_CAUSE_W-1:0]))
                      | cause_evt_w;
    assign irq = |(irq_stat_q & irq_mask_q);

    // master reset is a flop: no glitch on the wide reset tree, one cycle late
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            master_reset_signal <= 1'b1;
        end else begin
            master_reset_signal <= any_rst_w;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cause_q          <= `RRS_CAUSE_POR_VAL;
            cause_set_prev_q <= '0;
            irq_stat_q       <= `RRS_IRQ_STAT_RST;
            irq_mask_q       <= `RRS_IRQ_MASK_RST;
        end else begin
            cause_q          <= cause_d;
            cause_set_prev_q <= cause_set_w;
            irq_stat_q       <= irq_stat_d;
            if (irq_mask_wr_w) irq_mask_q <= wr_req.data[`RRS_CAUSE_W-1:0];
        end
    end

    // keep register is untouched by the master reset; only power-on clears it
    genvar gi;
    generate
        for (gi = 0; gi < `RRS_DATA_W/8; gi++) begin : g_keep
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    keep_q[gi*8 +: 8] <= 8'(`RRS_KEEP_RST >> (gi*8));
                end else if (keep_wr_w && wr_req.strb[gi]) begin
                    keep_q[gi*8 +: 8] <= wr_req.data[gi*8 +: 8];
                end
            end
        end
    endgenerate

    // volatile register loses writes made while master reset is active
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            volatile_q <= `RRS_VOLATILE_RST;
        end else if (master_reset_signal) begin
            volatile_q <= `RRS_VOLATILE_RST;
        end else if (volatile_wr_w) begin
            volatile_q <= (volatile_q & ~{{8{wr_req.strb[3]}}, {8{wr_req.strb[2]}},
                                          {8{wr_req.strb[1]}}, {8{wr_req.strb[0]}}})
                        | (wr_req.data & {{8{wr_req.strb[3]}}, {8{wr_req.strb[2]}},
                                          {8{wr_req.strb[1]}}, {8{wr_req.strb[0]}}});
        end
    end

    always_comb begin
        rd_mux = '0;
        if (reg_hit(rd_addr, `RRS_OFF_CAUSE)) rd_mux[`RRS_CAUSE_W-1:0] = cause_q;
        if (reg_hit(rd_addr, `RRS_OFF_IRQ_STAT)) rd_mux[`RRS_CAUSE_W-1:0] = irq_stat_q;
        if (reg_hit(rd_addr, `RRS_OFF_IRQ_MASK)) rd_mux[`RRS_CAUSE_W-1:0] = irq_mask_q;
        if (reg_hit(rd_addr, `RRS_OFF_KEEP)) rd_mux = keep_q;
        if (reg_hit(rd_addr, `RRS_OFF_VOLATILE)) rd_mux = volatile_q;
        if (reg_hit(rd_addr, `RRS_OFF_SRC_LIVE)) rd_mux[$bits(src)-1:0] = src;
    end

    assign rd_ans.data = rd_mux;
    assign rd_ans.resp = rd_err ? `RRS_RESP_DECERR : `RRS_RESP_OKAY;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic [`RRS_CAUSE_W-1:0] cause_new_v;
    assign cause_new_v = wr_req.data[`RRS_CAUSE_W-1:0];

    property p_src_asserts_reset;
        src_any |=> master_reset_signal;
    endproperty
    a_src_asserts_reset: assert property (p_src_asserts_reset)
        else $error("active source did not raise master reset");

    property p_reset_follows_sources;
        1'b1 |=> master_reset_signal == $past(any_rst_w);
    endproperty
    a_reset_follows_sources: assert property (p_reset_follows_sources)
        else $error("master reset does not track combined sources");

    property p_volatile_forced;
        master_reset_signal |=> volatile_q == `RRS_VOLATILE_RST;
    endproperty
    a_volatile_forced: assert property (p_volatile_forced)
        else $error("volatile register not forced by master reset");

    property p_keep_survives;
        master_reset_signal && !keep_wr_w |=> $stable(keep_q);
    endproperty
    a_keep_survives: assert property (p_keep_survives)
        else $error("keep register changed under master reset");

    property p_cause_set;
        (|cause_set_w) |=> ((cause_q & $past(cause_set_w)) == $past(cause_set_w));
    endproperty
    a_cause_set: assert property (p_cause_set)
        else $error("reset kind did not set its cause flag");

    property p_illegal_flag;
        (src.illegal_opcode || src.uninit_wreg || src.security)
            |=> cause_q[`RRS_BIT_ILLEG] ##1 master_reset_signal || cause_q[`RRS_BIT_ILLEG]
                || $past(cause_wr_w);
    endproperty
    a_illegal_flag: assert property (p_illegal_flag)
        else $error("illegal condition flag not set");

    property p_por_only;
        $past(!aresetn) |-> cause_q == `RRS_CAUSE_POR_VAL;
    endproperty
    a_por_only: assert property (disable iff (1'b0) p_por_only)
        else $error("cause register wrong after power-on");

    property p_flags_kept;
        !cause_wr_w |=> ((cause_q & $past(cause_q)) == $past(cause_q));
    endproperty
    a_flags_kept: assert property (p_flags_kept)
        else $error("cause flag dropped without a write");

    property p_sw_write;
        cause_wr_w |=> cause_q == ($past(cause_new_v) | $past(cause_set_w));
    endproperty
    a_sw_write: assert property (p_sw_write)
        else $error("software write to cause register not stored");

    property p_write_no_reset;
        cause_wr_w && !src_any |=> !master_reset_signal;
    endproperty
    a_write_no_reset: assert property (p_write_no_reset)
        else $error("cause write started a reset");

    c_wdog_then_clear: cover property (src.watchdog_timeout_reset ##[1:50] cause_wr_w);
    c_irq_raised: cover property (!irq ##1 irq);
    c_illegal_seen: cover property (src.security ##1 cause_q[`RRS_BIT_ILLEG]);
endmodule

// >>> tb.sv
// Purpose: self-checking bench of the reset source combiner and cause recorder
// Assumes: no partner model; only the watchdog ends a bus wait
// Notes: random values come from a 16-bit lfsr with a fixed start
`timescale 1ns/10ps
`include "rrs_consts.svh"
`define CHK(nm, e, g) check(nm, 32'(e), 32'(g))
module tb;
    logic              aclk;
    logic              aresetn;
    rrs_pkg::rrs_src_t src;
    logic              mrst;
    logic              irq;
    logic [7:0]        awaddr, araddr;
    logic [31:0]       wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [15:0]       lfsr;
    logic [31:0]       rd, kv, vv;
    logic [1:0]        rs;
    logic [7:0]        exp_cause;
    logic [8:0]        sv;
    int                n_mismatch;
    int                compares;

    rrs_top DUT (.aclk(aclk), .aresetn(aresetn), .src(src), .master_reset_signal(mrst),
        .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    function automatic logic [15:0] rnd(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // illegal opcode, uninit register and security share one cause bit
    function automatic int cause_bit(input int k);
        return (k >= 3) ? 9 - k : 7;
    endfunction

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict;
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ready is sampled at the falling edge, where inputs are settled
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ah, wh, bh;
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= 4'hf;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(negedge aclk);
            ah = awvalid & awready; wh = wvalid & wready; bh = bvalid & bready; r = bresp;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end while (!bh);
        bready <= 1'b0;
        @(negedge aclk);
        `CHK("write answer drops", 0, bvalid);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ah, rh;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(negedge aclk);
            ah = arvalid & arready; rh = rvalid & rready; d = rdata; r = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
        end while (!rh);
        rready <= 1'b0;
        @(negedge aclk);
        `CHK("read answer drops", 0, rvalid);
    endtask

    task automatic pulse(input logic [8:0] v);
        @(posedge aclk);
        src <= v;
        @(posedge aclk);
        src <= '0;
        @(negedge aclk);
        `CHK("master reset on", 1, mrst);
        @(negedge aclk);
        `CHK("master reset off", 0, mrst);
    endtask

    task automatic por;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        `CHK("master reset in por", 1, mrst);
    endtask

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        aresetn = 1'b0; src = '0; awaddr = '0; wdata = '0; wstrb = '0; awvalid = 1'b0;
        wvalid = 1'b0; bready = 1'b0; araddr = '0; arvalid = 1'b0; rready = 1'b0;
        lfsr = 16'hdc8b; n_mismatch = 0; compares = 0;
        por();
        axi_rd(`RRS_OFF_CAUSE, rd, rs);
        `CHK("cause after por", 32'h01, rd);
        `CHK("cause rresp", `RRS_RESP_OKAY, rs);
        axi_rd(`RRS_OFF_KEEP, rd, rs);
        `CHK("keep after por", 0, rd);
        exp_cause = 8'h01;
        for (int k = 8; k >= 0; k--) begin
            pulse(9'h001 << k);
            exp_cause[cause_bit(k)] = 1'b1;
            axi_rd(`RRS_OFF_CAUSE, rd, rs);
            `CHK("cause accumulates", exp_cause, rd);
            `CHK("masked irq", 0, irq);
        end
        for (int i = 0; i < 4; i++) begin
            lfsr = rnd(lfsr);
            axi_wr(`RRS_OFF_CAUSE, {16'h0, lfsr}, rs);
            @(negedge aclk);
            `CHK("sw write no reset", 0, mrst);
            axi_rd(`RRS_OFF_CAUSE, rd, rs);
            `CHK("cause sw value", lfsr[7:0], rd);
        end
        axi_wr(`RRS_OFF_CAUSE, 32'h0, rs);
        axi_rd(`RRS_OFF_CAUSE, rd, rs);
        `CHK("cause cleared", 0, rd);
        lfsr = rnd(lfsr); kv = {lfsr, ~lfsr};
        lfsr = rnd(lfsr); vv = {~lfsr, lfsr};
        axi_wr(`RRS_OFF_KEEP, kv, rs);
        `CHK("keep bresp", `RRS_RESP_OKAY, rs);
        axi_wr(`RRS_OFF_VOLATILE, vv, rs);
        axi_rd(`RRS_OFF_VOLATILE, rd, rs);
        `CHK("volatile stored", vv, rd);
        pulse(9'h020);
        axi_rd(`RRS_OFF_KEEP, rd, rs);
        `CHK("keep survives", kv, rd);
        axi_rd(`RRS_OFF_VOLATILE, rd, rs);
        `CHK("volatile forced", 0, rd);
        axi_wr(`RRS_OFF_IRQ_MASK, 32'h04, rs);
        @(negedge aclk);
        `CHK("irq unmasked", 1, irq);
        axi_wr(`RRS_OFF_IRQ_STAT, 32'h04, rs);
        @(negedge aclk);
        `CHK("irq cleared", 0, irq);
        pulse(9'h080);
        `CHK("irq again", 1, irq);
        lfsr = rnd(lfsr);
        sv = lfsr[8:0] | 9'h001;
        @(posedge aclk);
        src <= sv;
        axi_rd(`RRS_OFF_SRC_LIVE, rd, rs);
        `CHK("live sources", sv, rd);
        `CHK("held reset", 1, mrst);
        @(posedge aclk);
        src <= '0;
        axi_rd(8'h20, rd, rs);
        `CHK("unmapped rresp", `RRS_RESP_DECERR, rs);
        `CHK("unmapped rdata", 0, rd);
        axi_wr(8'h20, 32'hffff_ffff, rs);
        `CHK("unmapped bresp", `RRS_RESP_DECERR, rs);
        axi_wr(`RRS_OFF_CAUSE, 32'hfe, rs);
        axi_rd(`RRS_OFF_CAUSE, rd, rs);
        `CHK("cause before second por", 32'hfe, rd);
        @(posedge aclk);
        por();
        axi_rd(`RRS_OFF_CAUSE, rd, rs);
        `CHK("cause after second por", 32'h01, rd);
        print_verdict();
    end
endmodule
